// file: fio_defines.vh
`ifndef FIO_DEFINES_VH
`define FIO_DEFINES_VH

// Register byte offsets
`define FIO_REG_CTRL 12'h000
`define FIO_REG_STATUS 12'h004
`define FIO_REG_OUT 12'h008
`define FIO_REG_INPUTS 12'h00c
`define FIO_REG_IRQ_STAT 12'h010
`define FIO_REG_IRQ_MASK 12'h014
`define FIO_REG_CMD 12'h018

// CTRL fields
`define FIO_CTRL_RUN 0
`define FIO_CTRL_MSG 1

// STATUS fields
`define FIO_ST_EIGHT 0
`define FIO_ST_SECOND 1
`define FIO_ST_IN_CABLE 2
`define FIO_ST_OUT_CABLE 3
`define FIO_ST_SUPPLY 4
`define FIO_ST_COMMS_LOST 5
`define FIO_ST_RUNNING 6

// Interrupt status bits
`define FIO_IRQ_INPUT 0
`define FIO_IRQ_COMMS 1
`define FIO_IRQ_IN_CABLE 2
`define FIO_IRQ_OUT_CABLE 3
`define FIO_IRQ_SUPPLY 4

// CMD fields: bit 8 = on/off, bits 3:0 output number (8 = daily event)
`define FIO_CMD_ON 8
`define FIO_CMD_DAILY 4'h8

// Timing
`define FIO_CLK_HZ 40000000
`define FIO_COMMS_TIMEOUT_S 3
`define FIO_COMMS_CYCLES (`FIO_COMMS_TIMEOUT_S * `FIO_CLK_HZ)
`define FIO_DEBOUNCE_MS 20
`define FIO_DEBOUNCE_CYCLES (`FIO_DEBOUNCE_MS * (`FIO_CLK_HZ / 1000))
`define FIO_FLASH_MS 250
`define FIO_FLASH_CYCLES (`FIO_FLASH_MS * (`FIO_CLK_HZ / 1000))
`define FIO_NOTIFY_MS 500
`define FIO_NOTIFY_CYCLES (`FIO_NOTIFY_MS * (`FIO_CLK_HZ / 1000))
`define FIO_START_CYCLES 16

`endif

// file: fio_field_io.v
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`include "fio_defines.vh"
`default_nettype none

module fio_field_io #(
    parameter integer COMMS_CYCLES = `FIO_COMMS_CYCLES,
    parameter integer DEBOUNCE_CYCLES = `FIO_DEBOUNCE_CYCLES,
    parameter integer FLASH_CYCLES = `FIO_FLASH_CYCLES,
    parameter integer NOTIFY_CYCLES = `FIO_NOTIFY_CYCLES
) (
    // Clock and reset
    input wire mclk_i,
    input wire reset_i,
    // AHB-Lite slave
    input wire hsel_i,
    input wire [11:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    output reg irq_o,
    // Field pins
    input wire [15:0] field_in_n_i,
    input wire field_supply_ok_i,
    input wire eight_input_link_i,
    input wire second_module_i,
    input wire [1:0] input_cable_code_i,
    input wire out_cable_code_i,
    output reg [7:0] ped_wait_n_o,
    output reg daily_event_n_o,
    // Indicators
    output reg power_indicator_o,
    output reg health_indicator_o,
    output reg [15:0] input_indicator_o,
    // Notification pulse towards the CAN side
    output reg cpu_notify_o
);

    localparam [1:0] ST_RESET = 2'd0;
    localparam [1:0] ST_START = 2'd1;
    localparam [1:0] ST_RUN = 2'd2;

    function [31:0] sat_inc;
        input [31:0] v;
        begin
            sat_inc = (v == 32'hffffffff) ? v : v + 32'h00000001;
        end
    endfunction

    // Two-flop synchronisers for every field input pin
    reg [20:0] sync1;
    reg [20:0] sync2;
    always @(posedge mclk_i) begin
        sync1 <= {field_in_n_i, field_supply_ok_i, eight_input_link_i, second_module_i,
            input_cable_code_i};
        sync2 <= sync1;
    end
    wire [15:0] in_n_s = sync2[20:5];
    wire supply_ok_s = sync2[4];
    wire link_s = sync2[3];
    wire second_s = sync2[2];
    wire [1:0] in_code_s = sync2[1:0];
    reg out_code1;
    reg out_code_s;
    always @(posedge mclk_i) begin
        out_code1 <= out_cable_code_i;
        out_code_s <= out_code1;
    end

    // Configuration straps caught after reset release
    reg [1:0] state;
    reg [4:0] start_cnt;
    reg eight_mode;
    reg second_mode;
    always @(posedge mclk_i) begin
        if (reset_i) begin
            state <= ST_RESET;
            start_cnt <= 5'h00;
            eight_mode <= 1'b0;
            second_mode <= 1'b0;
        end else begin
            case (state)
                ST_RESET: begin
                    eight_mode <= link_s;
                    second_mode <= second_s;
                    state <= ST_START;
                end
                ST_START: begin
                    start_cnt <= start_cnt + 5'h01;
                    if (start_cnt == `FIO_START_CYCLES - 1)
                        state <= ST_RUN;
                end
                ST_RUN: state <= ST_RUN;
                default: state <= ST_RESET;
            endcase
        end
    end
    wire running = (state == ST_RUN);

    // Expected coding link: first module 2'b01, second module 2'b10
    wire in_cable_ok = second_mode ? (in_code_s == 2'b10) : (in_code_s == 2'b01);
    wire out_cable_ok = out_code_s;

    // Debounce: a level must be stable for the whole window to be accepted
    reg [15:0] deb_state;
    reg [31:0] deb_cnt [0:15];
    integer i;
    always @(posedge mclk_i) begin
        for (i = 0; i < 16; i = i + 1) begin
            if (reset_i) begin
                deb_state[i] <= 1'b0;
                deb_cnt[i] <= 32'h00000000;
            end else if (((~in_n_s[i]) == deb_state[i]) || !running) begin
                deb_cnt[i] <= 32'h00000000;
            end else if (deb_cnt[i] >= DEBOUNCE_CYCLES - 1) begin
                deb_state[i] <= ~in_n_s[i];
                deb_cnt[i] <= 32'h00000000;
            end else begin
                deb_cnt[i] <= sat_inc(deb_cnt[i]);
            end
        end
    end

    // Unused upper inputs are reported inactive in the 8-input build
    wire [15:0] cfg_mask = eight_mode ? 16'h00ff : 16'hffff;
    wire lock_all = !supply_ok_s || !in_cable_ok;
    wire [15:0] eff_inputs = (lock_all ? 16'hffff : deb_state) & cfg_mask;

    // Comms supervision, retriggered by each valid CPU message
    reg ctrl_msg_pulse;
    reg [31:0] comms_cnt;
    reg comms_lost;
    reg [31:0] flash_cnt;
    reg flash_phase;
    reg [31:0] notify_cnt;
    always @(posedge mclk_i) begin
        if (reset_i || !running || ctrl_msg_pulse) begin
            comms_cnt <= 32'h00000000;
            comms_lost <= 1'b0;
        end else if (comms_cnt >= COMMS_CYCLES - 1) begin
            comms_lost <= 1'b1;
        end else begin
            comms_cnt <= sat_inc(comms_cnt);
        end
    end
    always @(posedge mclk_i) begin
        if (reset_i || !comms_lost) begin
            flash_cnt <= 32'h00000000;
            flash_phase <= 1'b1;
        end else if (flash_cnt >= FLASH_CYCLES - 1) begin
            flash_cnt <= 32'h00000000;
            flash_phase <= ~flash_phase;
        end else begin
            flash_cnt <= sat_inc(flash_cnt);
        end
    end
    wire notify_due = comms_lost || !in_cable_ok || (!out_cable_ok && !second_mode);
    always @(posedge mclk_i) begin
        if (reset_i || !running || !notify_due) begin
            notify_cnt <= 32'h00000000;
            cpu_notify_o <= 1'b0;
        end else if (notify_cnt >= NOTIFY_CYCLES - 1) begin
            notify_cnt <= 32'h00000000;
            cpu_notify_o <= 1'b1;
        end else begin
            notify_cnt <= sat_inc(notify_cnt);
            cpu_notify_o <= 1'b0;
        end
    end

    // AHB-Lite slave, zero wait state
    reg ph_wr;
    reg ph_rd;
    reg [11:0] ph_addr;
    reg [8:0] out_latch;
    reg [4:0] irq_stat;
    reg [4:0] irq_mask;
    reg run_req;
    wire acc = hsel_i && htrans_i[1] && hready_i;
    wire [31:0] status_word = {25'h0000000, running, comms_lost, !supply_ok_s,
        !out_cable_ok, !in_cable_ok, second_mode, eight_mode};
    reg [15:0] prev_inputs;
    reg prev_comms;
    wire [4:0] ev = {!supply_ok_s, !out_cable_ok && !second_mode, !in_cable_ok,
        comms_lost && !prev_comms, |(eff_inputs & ~prev_inputs)};

    always @(posedge mclk_i) begin
        if (reset_i) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_addr <= 12'h000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            hrdata_o <= 32'h00000000;
            out_latch <= 9'h000;
            irq_stat <= 5'h00;
            irq_mask <= 5'h00;
            run_req <= 1'b0;
            ctrl_msg_pulse <= 1'b0;
            prev_inputs <= 16'h0000;
            prev_comms <= 1'b0;
        end else begin
            ph_wr <= acc && hwrite_i;
            ph_rd <= acc && !hwrite_i;
            ph_addr <= haddr_i;
            ctrl_msg_pulse <= 1'b0;
            prev_inputs <= eff_inputs;
            prev_comms <= comms_lost;
            if (acc && !hwrite_i) begin
                case (haddr_i)
                    `FIO_REG_CTRL: hrdata_o <= {31'h00000000, run_req};
                    `FIO_REG_STATUS: hrdata_o <= status_word;
                    `FIO_REG_OUT: hrdata_o <= {23'h000000, out_latch};
                    `FIO_REG_INPUTS: hrdata_o <= {16'h0000, eff_inputs};
                    `FIO_REG_IRQ_STAT: hrdata_o <= {27'h0000000, irq_stat};
                    `FIO_REG_IRQ_MASK: hrdata_o <= {27'h0000000, irq_mask};
                    default: hrdata_o <= 32'h00000000;
                endcase
            end
            // Set wins over a write-one clear in the same cycle
            irq_stat <= (irq_stat & ~((ph_wr && ph_addr == `FIO_REG_IRQ_STAT) ?
                hwdata_i[4:0] : 5'h00)) | (running ? ev : 5'h00);
            if (ph_wr) begin
                case (ph_addr)
                    `FIO_REG_CTRL: begin
                        run_req <= hwdata_i[`FIO_CTRL_RUN];
                        ctrl_msg_pulse <= hwdata_i[`FIO_CTRL_MSG];
                    end
                    `FIO_REG_IRQ_MASK: irq_mask <= hwdata_i[4:0];
                    `FIO_REG_CMD: begin
                        ctrl_msg_pulse <= 1'b1;
                        if (hwdata_i[3:0] <= `FIO_CMD_DAILY)
                            out_latch[hwdata_i[3:0]] <= hwdata_i[`FIO_CMD_ON];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Registered outputs
    always @(posedge mclk_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
            ped_wait_n_o <= 8'hff;
            daily_event_n_o <= 1'b1;
            power_indicator_o <= 1'b0;
            health_indicator_o <= 1'b0;
            input_indicator_o <= 16'h0000;
        end else begin
            irq_o <= |(irq_stat & irq_mask);
            ped_wait_n_o <= second_mode ? 8'hff : ~out_latch[7:0];
            daily_event_n_o <= second_mode ? 1'b1 : ~out_latch[8];
            power_indicator_o <= 1'b1;
            health_indicator_o <= running && flash_phase;
            input_indicator_o <= running ? eff_inputs : 16'h0000;
        end
    end

endmodule
`default_nettype wire

// file: fio_field_io_asserts.sv
`default_nettype none
module fio_field_io_asserts (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Bus, straps and field inputs
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic field_supply_ok_i,
    input wire logic second_module_i,
    input wire logic [15:0] field_in_n_i,
    // Outputs watched
    input wire logic [7:0] ped_wait_n_o,
    input wire logic daily_event_n_o,
    input wire logic power_indicator_o,
    input wire logic health_indicator_o,
    input wire logic [15:0] input_indicator_o,
    input wire logic cpu_notify_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] run_cnt;
    logic cmd_wr;
    assign cmd_wr = hsel_i && htrans_i[1] && hwrite_i && haddr_i == 12'h018;
    always_ff @(posedge mclk_i)
        if (reset_i) run_cnt <= 5'h00;
        else if (run_cnt != 5'h1f) run_cnt <= run_cnt + 5'h01;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    property p_okay; hreadyout_o && !hresp_o; endproperty
    property p_power; run_cnt != 5'h00 |-> power_indicator_o; endproperty
    property p_alone; run_cnt < 5'h10 |-> input_indicator_o == 16'h0000 && !health_indicator_o;
    endproperty
    property p_second; second_module_i |-> ped_wait_n_o == 8'hff && daily_event_n_o; endproperty
    property p_supply; !field_supply_ok_i [*8] ##0 run_cnt > 5'h18 |->
        input_indicator_o[7:0] == 8'hff; endproperty
    property p_actuate; !field_in_n_i[0] [*8] ##0 run_cnt > 5'h18 |-> input_indicator_o[0];
    endproperty
    // The output may lag the write by one register stage
    property p_latch; $changed({daily_event_n_o, ped_wait_n_o}) |->
        $past(cmd_wr, 2) || $past(cmd_wr, 3); endproperty
    property p_on; cmd_wr && !second_module_i ##1 hwdata_i[8] && hwdata_i[3:0] == 4'h0 |=>
        ##[0:1] !ped_wait_n_o[0]; endproperty
    property p_pulse; cpu_notify_o |=> !cpu_notify_o; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not OKAY");
    a_power: assert property (p_power) else $error("power lamp off");
    a_alone: assert property (p_alone) else $error("lamp lit too early");
    a_second: assert property (p_second) else $error("second module drives");
    a_supply: assert property (p_supply) else $error("inputs not forced");
    a_actuate: assert property (p_actuate) else $error("low input not seen");
    a_latch: assert property (p_latch) else $error("output moved alone");
    a_on: assert property (p_on) else $error("output not driven low");
    a_pulse: assert property (p_pulse) else $error("notify not a pulse");
    c_cmd: cover property (cmd_wr);
    c_notify: cover property (cpu_notify_o);
    c_nosupply: cover property (!field_supply_ok_i ##1 !field_supply_ok_i);
endmodule
bind fio_field_io fio_field_io_asserts u_chk (
    .mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .field_supply_ok_i(field_supply_ok_i),
    .second_module_i(second_module_i), .field_in_n_i(field_in_n_i),
    .ped_wait_n_o(ped_wait_n_o), .daily_event_n_o(daily_event_n_o),
    .power_indicator_o(power_indicator_o), .health_indicator_o(health_indicator_o),
    .input_indicator_o(input_indicator_o), .cpu_notify_o(cpu_notify_o));
`default_nettype wire

// file: fio_cpu_model.sv
`default_nettype none
module fio_cpu_model (
    input wire logic mclk_i,
    input wire logic clear_i,
    input wire logic notify_i,
    output logic [7:0] notify_count_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Counts CAN-side notifications; saturates so a long fault cannot wrap to zero
    always_ff @(posedge mclk_i)
        if (clear_i) notify_count_o <= 8'h00;
        else if (notify_i && notify_count_o != 8'hff) notify_count_o <= notify_count_o + 8'h01;
endmodule
`default_nettype wire

// file: testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [11:0] haddr_i = 12'h000;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic [15:0] field_in_n_i = 16'hffff;
    logic supply_ok = 1'b1, link = 1'b0, second = 1'b0, out_code = 1'b1, clr = 1'b0;
    logic [1:0] in_code = 2'h1;
    logic [31:0] rdat;
    wire [31:0] hrdata_o;
    wire hreadyout_o, hresp_o, irq_o, daily_event_n_o, power_ind, health, notify;
    wire [7:0] ped_wait_n_o, ncount;
    wire [15:0] ind;
    int num_errors = 0, tests_run = 0, cycles = 0, tg = 0;
    logic h;
    always #12.5 mclk_i = ~mclk_i;
    fio_field_io #(.COMMS_CYCLES(200), .DEBOUNCE_CYCLES(4), .FLASH_CYCLES(8),
        .NOTIFY_CYCLES(20)) u_dut (
        .mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .irq_o(irq_o), .field_in_n_i(field_in_n_i),
        .field_supply_ok_i(supply_ok), .eight_input_link_i(link), .second_module_i(second),
        .input_cable_code_i(in_code), .out_cable_code_i(out_code),
        .ped_wait_n_o(ped_wait_n_o), .daily_event_n_o(daily_event_n_o),
        .power_indicator_o(power_ind), .health_indicator_o(health),
        .input_indicator_o(ind), .cpu_notify_o(notify));
    fio_cpu_model u_cpu (.mclk_i(mclk_i), .clear_i(clr), .notify_i(notify),
        .notify_count_o(ncount));
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cycles = cycles + 1;
        if (cycles == 6000) begin
            num_errors = num_errors + 1;
            conclude();
        end
    end
    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic chk(input string what, input [31:0] exp, input [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Address phase held until hready, then data phase held until hready again
    task automatic xfer(input logic w, input [11:0] a, input [31:0] d);
        @(posedge mclk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        if (w) hwdata_i <= d;
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        rdat = hrdata_o;
    endtask
    task automatic wr(input [11:0] a, input [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rchk(input string what, input [11:0] a, input [31:0] m, input [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(what, e, rdat & m);
    endtask
    task automatic rst(input logic l, input logic s, input logic [1:0] c);
        reset_i <= 1'b1;
        link <= l;
        second <= s;
        in_code <= c;
        idle(20);
        reset_i <= 1'b0;
        idle(20);
    endtask
    initial begin
        rst(1'b0, 1'b0, 2'h1);
        chk("power", 1, power_ind);
        rchk("status", 12'h004, 32'h5f, 32'h40);
        $display("test reset done");
        for (int i = 0; i < 9; i++) wr(12'h018, 32'h100 | i);
        idle(2);
        chk("outs on", 32'h0, {daily_event_n_o, ped_wait_n_o});
        wr(12'h018, 32'h109);
        for (int i = 0; i < 9; i += 2) wr(12'h018, i);
        idle(150);
        chk("latched", 32'h155, {daily_event_n_o, ped_wait_n_o});
        rchk("out reg", 12'h008, 32'h1ff, 32'h0aa);
        rchk("unmapped", 12'h020, 32'hffffffff, 32'h0);
        $display("test outputs done");
        wr(12'h014, 32'h1);
        wr(12'h010, 32'h1f);
        // Bursts shorter than the filter must not count as a press
        repeat (6) begin
            field_in_n_i[3] <= ~field_in_n_i[3];
            idle(2);
        end
        idle(8);
        chk("bounce", 0, irq_o);
        field_in_n_i[3] <= 1'b0;
        idle(12);
        rchk("inputs", 12'h00c, 32'hffff, 32'h0008);
        chk("lamps", 32'h0008, ind);
        chk("irq", 1, irq_o);
        field_in_n_i[3] <= 1'b1;
        idle(12);
        wr(12'h010, 32'h1);
        wr(12'h014, 32'h0);
        field_in_n_i[3] <= 1'b0;
        idle(12);
        chk("irq masked", 0, irq_o);
        field_in_n_i[3] <= 1'b1;
        supply_ok <= 1'b0;
        idle(12);
        chk("no supply", 32'hffff, ind);
        rchk("supply bit", 12'h004, 32'h10, 32'h10);
        supply_ok <= 1'b1;
        $display("test inputs done");
        wr(12'h000, 32'h3);
        in_code <= 2'h0;
        out_code <= 1'b0;
        clr <= 1'b1;
        idle(2);
        clr <= 1'b0;
        idle(60);
        rchk("cable bits", 12'h004, 32'hc, 32'hc);
        rchk("locked", 12'h00c, 32'hffff, 32'hffff);
        chk("notified", 1, ncount >= 8'h02);
        in_code <= 2'h2;
        out_code <= 1'b1;
        idle(12);
        rchk("wrong lead", 12'h004, 32'hc, 32'h4);
        in_code <= 2'h1;
        wr(12'h000, 32'h3);
        clr <= 1'b1;
        idle(2);
        clr <= 1'b0;
        idle(60);
        chk("quiet", 0, ncount);
        idle(200);
        rchk("comms lost", 12'h004, 32'h20, 32'h20);
        repeat (40) begin
            h = health;
            @(posedge mclk_i);
            if (health !== h) tg++;
        end
        chk("flash", 1, tg > 2);
        wr(12'h000, 32'h3);
        idle(4);
        rchk("restored", 12'h004, 32'h20, 32'h0);
        chk("steady", 1, health);
        $display("test comms done");
        rst(1'b1, 1'b1, 2'h2);
        rchk("straps", 12'h004, 32'h47, 32'h43);
        wr(12'h018, 32'h100);
        idle(2);
        chk("dead outs", 32'h1ff, {daily_event_n_o, ped_wait_n_o});
        field_in_n_i <= 16'h0000;
        idle(12);
        rchk("eight", 12'h00c, 32'hffff, 32'h00ff);
        chk("eight lamps", 32'h00ff, ind);
        $display("test second module done");
        conclude();
    end
endmodule
`default_nettype wire
